// [core/serial_port_pkg.sv]
/*
 * Shared constants and state types for the clocked serial port.
 * Assumes an AXI4-Lite register bus with byte lane 0 carrying all fields but the receive overrun flag at bit 12.
 */
package serial_port_pkg;

	// register byte offsets
	localparam int         ADDR_W       = 6;
	localparam logic [5:0] OFS_TX_BUF   = 6'h00;
	localparam logic [5:0] OFS_RX_BUF   = 6'h04;
	localparam logic [5:0] OFS_BAUD     = 6'h08;
	localparam logic [5:0] OFS_MODE     = 6'h0C;
	localparam logic [5:0] OFS_CTRL0    = 6'h10;
	localparam logic [5:0] OFS_CTRL1    = 6'h14;
	localparam logic [5:0] OFS_SPEC1    = 6'h18;
	localparam logic [5:0] OFS_SPEC2    = 6'h1C;
	localparam logic [5:0] OFS_SPEC3    = 6'h20;
	localparam logic [5:0] OFS_SPEC4    = 6'h24;
	localparam logic [5:0] OFS_SHARED   = 6'h28;
	localparam logic [5:0] OFS_IRQ_CTL  = 6'h2C;

	// serial_mode fields
	localparam int         MODE_CLK_SRC  = 3;
	localparam int         MODE_DATA_INV = 6;
	localparam logic [2:0] MODE_CLK_SYNC = 3'h1;

	// transfer_control_zero fields
	localparam int C0_HS_PIN   = 2;
	localparam int C0_TX_EMPTY = 3;
	localparam int C0_HS_OFF   = 4;
	localparam int C0_DRIVE    = 5;
	localparam int C0_EDGE     = 6;
	localparam int C0_ORDER    = 7;

	// transfer_control_one fields
	localparam int C1_TX_EN     = 0;
	localparam int C1_TX_EMPTY  = 1;
	localparam int C1_RX_EN     = 2;
	localparam int C1_RX_DONE   = 3;
	localparam int C1_IRQ_CAUSE = 4;
	localparam int C1_CONT_RX   = 5;
	localparam int C1_LOGIC_INV = 6;

	// tx_irq_control and rx_data_buffer fields
	localparam int IRQ_REQ     = 3;
	localparam int RX_OVERRUN  = 12;

	// reset values
	localparam logic [7:0] REG_RST  = 8'h00;
	localparam logic [7:0] CTRL0_RST = 8'h00;

	// prescaler terminal counts for divider_source_bits 0..3
	localparam logic [5:0] PRE_TOP_F1  = 6'h00;
	localparam logic [5:0] PRE_TOP_F8  = 6'h07;
	localparam logic [5:0] PRE_TOP_F32 = 6'h1F;
	localparam logic [5:0] PRE_TOP_F2  = 6'h01;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} xfer_state_t;

	typedef struct packed {
		logic [5:0] pre_cnt;
		logic [7:0] div_cnt;
		logic       tick;
	} baud_state_t;

	typedef struct packed {
		xfer_state_t     st;
		logic [7:0]      tx_buf;
		logic [7:0]      rx_buf;
		logic [7:0]      baud;
		logic [7:0]      mode;
		logic [7:0]      ctrl0;
		logic [7:0]      ctrl1;
		logic [3:0][7:0] spec;
		logic [7:0]      shared;
		logic [7:0]      irq_ctl;
		logic            tx_buf_empty;
		logic            tx_shift_empty;
		logic            rx_done;
		logic            rx_overrun;
		logic [7:0]      shift;
		logic [2:0]      bit_cnt;
		logic            sclk;
		logic            sclk_oe;
		logic            txd;
		logic            txd_oe;
		logic            rts_n;
		logic [2:0]      rxd_sync;
		logic            rxd_f;
		logic [2:0]      cts_sync;
		logic            cts_f;
		logic            aw_held;
		logic [5:0]      awaddr;
		logic            w_held;
		logic [7:0]      wdata;
		logic            wstrb0;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} port_state_t;

endpackage

// [core/baud_tick_gen.sv]
/*
 * Prescaler and eight-bit divider giving one tick per half transfer clock.
 * Assumes run is held high for the whole of a transfer.
 */
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       run,
	input  wire logic [1:0] src,
	input  wire logic [7:0] div,
	// half-period tick
	output logic            half_tick
);

	baud_state_t q;
	baud_state_t n;

	// prescaled count source selection
	function automatic logic [5:0] pre_top(input logic [1:0] s);
		unique case (s)
			2'h0:    pre_top = PRE_TOP_F1;
			2'h1:    pre_top = PRE_TOP_F8;
			2'h2:    pre_top = PRE_TOP_F32;
			default: pre_top = PRE_TOP_F2;
		endcase
	endfunction

	// counters restart whenever the transfer is not running
	always_comb
	begin
		n = q;
		n.tick = 1'b0;
		if (!run)
		begin
			n.pre_cnt = 6'h00;
			n.div_cnt = div;
		end
		else if (q.pre_cnt == pre_top(src))
		begin
			n.pre_cnt = 6'h00;
			if (q.div_cnt == 8'h00)
			begin
				n.div_cnt = div;
				n.tick = 1'b1;
			end
			else
				n.div_cnt = q.div_cnt - 8'h01;
		end
		else
			n.pre_cnt = q.pre_cnt + 6'h01;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= n;
	end

	assign half_tick = q.tick;

endmodule

`default_nettype wire

// [core/clock_sync_serial_port.sv]
/*
 * Clocked serial port: register file on AXI4-Lite, eight-bit full-duplex
 * shifter driving a transfer clock out and sampling receive data back.
 * Assumes the far end changes data on falling and samples on rising edges.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - serial_mode_field value 001b selects clocked serial operation.
// - clock_source_select 0 makes the transfer clock internally from the divider.
// - divider_source_bits pick the prescaled clock feeding the divider.
// - eight-bit divider value sets the transfer speed.
// - edge select 0: send on falling edge, sample on rising edge.
// - bit_order_select 1 shifts most significant bit first both ways.
// - handshake_disable 1 turns handshake off; pin select then ignored.
// - output_drive_select 0 drives outputs push-pull, 1 open-drain; only the data pin follows it, the clock pin stays push-pull.
// - no transmission while tx_enable is 0, its reset value.
// - no reception while rx_enable is 0, its reset value.
// - read-only tx_buffer_empty shows the buffer can take a byte.
// - cause select 0 requests transmit interrupt when the buffer empties.
// - read-only tx_shift_empty shows the last bit has gone out.
// - read-only rx_done_flag shows a byte waits in the receive buffer.
// - received byte in low bits; overrun flag when unread byte is overwritten.
// - byte to send comes from the software-written transmit buffer.
// - data_invert 0 passes serial levels unchanged.
// - logic invert 0 keeps data unreversed; no error signal is driven.
// - continuous receive off by default; when on, reads start dummy transfers.
// - clock pin mode bits 0 drive the clock on one pin only.
// - level 000b: no interrupt; request bit polled, cleared by writing 0.
// - the four special mode registers reset to 00.
module clock_sync_serial_port
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	// axi4-lite write response
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	// serial link
	output logic                   SCLK_OUT,
	output logic                   SCLK_OE,
	output logic                   TXD_OUT,
	output logic                   TXD_OE,
	input  wire logic              RXD_IN,
	// handshake pins
	input  wire logic              CTS_N_IN,
	output logic                   RTS_N_OUT
);

	port_state_t q;
	port_state_t n;
	logic        half_tick;
	logic        sync_mode;
	logic        msb_first;
	logic        inv;
	logic        hs_on;
	logic        cts_ok;
	logic        can_start;
	logic        rx_bit;
	logic        wr_go;
	logic        tx_wr;
	logic        rd_go;
	logic [31:0] rd_word;
	logic [7:0]  c0_rd;
	logic [7:0]  c1_rd;

	// address decode shared by both bus directions
	function automatic logic mapped(input logic [5:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFS_IRQ_CTL);
	endfunction

	// bit leaving the shifter for the chosen order
	function automatic logic out_bit(input logic [7:0] sh, input logic msb);
		out_bit = msb ? sh[7] : sh[0];
	endfunction

	// shifter after taking one received bit
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
		input logic msb);
		shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
	endfunction

	baud_tick_gen u_baud (
		.clk       (REF_CLK),
		.rst       (RST),
		.run       (q.st == ST_SHIFT),
		.src       (q.ctrl0[1:0]),
		.div       (q.baud),
		.half_tick (half_tick)
	);

	// read views of control registers with live status bits
	always_comb
	begin
		c0_rd = q.ctrl0;
		c0_rd[C0_TX_EMPTY] = q.tx_shift_empty;
		c1_rd = q.ctrl1;
		c1_rd[C1_TX_EMPTY] = q.tx_buf_empty;
		c1_rd[C1_RX_DONE] = q.rx_done;
		unique case (ARADDR)
			OFS_RX_BUF:  rd_word = {19'h0, q.rx_overrun, 4'h0, q.rx_buf};
			OFS_BAUD:    rd_word = {24'h0, q.baud};
			OFS_MODE:    rd_word = {24'h0, q.mode};
			OFS_CTRL0:   rd_word = {24'h0, c0_rd};
			OFS_CTRL1:   rd_word = {24'h0, c1_rd};
			OFS_SPEC1:   rd_word = {24'h0, q.spec[0]};
			OFS_SPEC2:   rd_word = {24'h0, q.spec[1]};
			OFS_SPEC3:   rd_word = {24'h0, q.spec[2]};
			OFS_SPEC4:   rd_word = {24'h0, q.spec[3]};
			OFS_SHARED:  rd_word = {24'h0, q.shared};
			OFS_IRQ_CTL: rd_word = {24'h0, q.irq_ctl};
			default:     rd_word = 32'h0000_0000;
		endcase
	end

	// mode decode
	always_comb
	begin
		sync_mode = (q.mode[2:0] == MODE_CLK_SYNC) && !q.mode[MODE_CLK_SRC];
		msb_first = q.ctrl0[C0_ORDER];
		inv = q.mode[MODE_DATA_INV] ^ q.ctrl1[C1_LOGIC_INV];
		hs_on = !q.ctrl0[C0_HS_OFF];
		cts_ok = !hs_on || q.ctrl0[C0_HS_PIN] || !q.cts_f;
		can_start = sync_mode && q.ctrl1[C1_TX_EN] && !q.tx_buf_empty && cts_ok;
		rx_bit = q.rxd_f ^ inv;
		wr_go = q.aw_held && q.w_held && !q.bvalid;
		tx_wr = wr_go && q.wstrb0 && (q.awaddr == OFS_TX_BUF);
		rd_go = ARVALID && q.arready;
	end

	// next state: pins, bus, registers, then the shifter
	always_comb
	begin
		n = q;

		// three-stage pin synchronisers, change taken when the last two stages agree
		n.rxd_sync = {q.rxd_sync[1:0], RXD_IN};
		n.cts_sync = {q.cts_sync[1:0], CTS_N_IN};
		if (q.rxd_sync[1] == q.rxd_sync[2])
			n.rxd_f = q.rxd_sync[2];
		if (q.cts_sync[1] == q.cts_sync[2])
			n.cts_f = q.cts_sync[2];

		// read channel; reading the receive buffer clears the done flag
		if (rd_go)
		begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rd_word;
			n.rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
			if (ARADDR == OFS_RX_BUF)
			begin
				n.rx_done = 1'b0;
				if (q.ctrl1[C1_CONT_RX] && q.ctrl1[C1_RX_EN])
					n.tx_buf_empty = 1'b0;
			end
		end
		if (q.rvalid && RREADY)
		begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// write address and data accepted in either order
		if (AWVALID && q.awready)
		begin
			n.aw_held = 1'b1;
			n.awaddr = AWADDR;
		end
		if (WVALID && q.wready)
		begin
			n.w_held = 1'b1;
			n.wdata = WDATA[7:0];
			n.wstrb0 = WSTRB[0];
		end
		if (q.bvalid && BREADY)
			n.bvalid = 1'b0;
		if (wr_go)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		// unmapped and read-only words change no register; the decoded response stands
		if (wr_go && q.wstrb0)
		begin
			unique case (q.awaddr)
				OFS_TX_BUF:
				begin
					n.tx_buf = q.wdata;
					n.tx_buf_empty = 1'b0;
				end
				OFS_BAUD:    n.baud = q.wdata;
				OFS_MODE:    n.mode = q.wdata;
				OFS_CTRL0:   n.ctrl0 = q.wdata;
				OFS_CTRL1:   n.ctrl1 = q.wdata;
				OFS_SPEC1:   n.spec[0] = q.wdata;
				OFS_SPEC2:   n.spec[1] = q.wdata;
				OFS_SPEC3:   n.spec[2] = q.wdata;
				OFS_SPEC4:   n.spec[3] = q.wdata;
				OFS_SHARED:  n.shared = q.wdata;
				OFS_IRQ_CTL:
				begin
					n.irq_ctl = q.wdata;
					n.irq_ctl[IRQ_REQ] = q.irq_ctl[IRQ_REQ] & q.wdata[IRQ_REQ];
				end
				default:     n.tx_buf = q.tx_buf;
			endcase
		end
		// ready again only once the previous write has been answered
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;

		// overrun stays until reception is switched off
		if (!q.ctrl1[C1_RX_EN])
			n.rx_overrun = 1'b0;

		// shifter; events set flags after any clear above
		unique case (q.st)
			ST_IDLE:
			begin
				n.sclk = 1'b1;
				if (can_start)
				begin
					n.st = ST_SHIFT;
					n.shift = q.tx_buf;
					n.bit_cnt = 3'h0;
					n.tx_shift_empty = 1'b0;
					if (!tx_wr)
						n.tx_buf_empty = 1'b1;
					if (!q.ctrl1[C1_IRQ_CAUSE])
						n.irq_ctl[IRQ_REQ] = 1'b1;
				end
			end
			ST_SHIFT:
			begin
				if (!sync_mode)
				begin
					n.st = ST_IDLE;
					n.sclk = 1'b1;
					n.tx_shift_empty = 1'b1;
				end
				else if (half_tick && q.sclk)
				begin
					n.sclk = 1'b0;
					n.txd = out_bit(q.shift, msb_first) ^ inv;
				end
				else if (half_tick)
				begin
					n.sclk = 1'b1;
					n.shift = shift_in(q.shift, rx_bit, msb_first);
					n.bit_cnt = q.bit_cnt + 3'h1;
					if (q.bit_cnt == 3'h7)
					begin
						n.st = ST_IDLE;
						n.tx_shift_empty = 1'b1;
						if (q.ctrl1[C1_IRQ_CAUSE])
							n.irq_ctl[IRQ_REQ] = 1'b1;
						if (q.ctrl1[C1_RX_EN])
						begin
							n.rx_overrun = n.rx_overrun | n.rx_done;
							n.rx_done = 1'b1;
							n.rx_buf = shift_in(q.shift, rx_bit, msb_first);
						end
					end
				end
			end
			default:
				n.st = ST_IDLE;
		endcase

		// pin drivers: push-pull or open-drain on the data pin
		n.sclk_oe = sync_mode;
		n.txd_oe = sync_mode && (!q.ctrl0[C0_DRIVE] || !n.txd);
		n.rts_n = !(hs_on && q.ctrl0[C0_HS_PIN] && q.ctrl1[C1_RX_EN] && !n.rx_done);
	end

	// state register with reset values
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ctrl0 <= CTRL0_RST;
			q.ctrl1 <= REG_RST;
			q.spec <= {4{REG_RST}};
			q.tx_buf_empty <= 1'b1;
			q.tx_shift_empty <= 1'b1;
			q.sclk <= 1'b1;
			q.txd <= 1'b1;
			q.rts_n <= 1'b1;
			q.rxd_sync <= 3'h7;
			q.rxd_f <= 1'b1;
			q.cts_sync <= 3'h7;
			q.cts_f <= 1'b1;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end
		else
			q <= n;
	end

	// outputs straight from the state register
	assign AWREADY   = q.awready;
	assign WREADY    = q.wready;
	assign BRESP     = q.bresp;
	assign BVALID    = q.bvalid;
	assign ARREADY   = q.arready;
	assign RDATA     = q.rdata;
	assign RRESP     = q.rresp;
	assign RVALID    = q.rvalid;
	assign SCLK_OUT  = q.sclk;
	assign SCLK_OE   = q.sclk_oe;
	assign TXD_OUT   = q.txd;
	assign TXD_OE    = q.txd_oe;
	assign RTS_N_OUT = q.rts_n;

endmodule

`default_nettype wire

// [verification/serial_port_sva.sv]
/* checker on the top ports of the clocked serial port
   assumes a bind from the bench top file */
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva
	import serial_port_pkg::*;
(
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RST,
	// register bus
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	// serial link
	input wire logic        SCLK_OUT,
	input wire logic        SCLK_OE,
	input wire logic        TXD_OUT,
	input wire logic        TXD_OE,
	input wire logic        RTS_N_OUT
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// outputs settle idle under reset
	a_reset_idle: assert property (disable iff (1'b0) RST |=> SCLK_OUT && TXD_OUT
		&& !SCLK_OE && !TXD_OE && RTS_N_OUT && !BVALID && !RVALID)
		else $error("outputs not idle after reset");
	// bus answers, holds and refusals
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
		|-> ##[1:2] BVALID) else $error("write not answered");
	a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped");
	a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("second write taken");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read not answered");
	a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data changed");
	a_err_zero: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
		else $error("error read carries data");
	// link pins
	a_clk_idle: assert property (!SCLK_OE |-> SCLK_OUT && !TXD_OE)
		else $error("link driven outside mode");
	a_tx_on_fall: assert property ($rose(SCLK_OUT) |-> $stable(TXD_OUT))
		else $error("data moved on rising clock");
	// main scenarios
	c_write: cover property (BVALID && BREADY);
	c_err: cover property (RVALID && RRESP == RESP_SLVERR);
	c_fall: cover property ($fell(SCLK_OUT));
endmodule
`default_nettype wire

// [verification/eeprom_link_model.sv]
/* far end of the link: shifts a reply byte out, captures sent bytes
   assumes the transfer clock idles high and runs only within frames */
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_model (
	// serial link
	input wire logic        sclk,
	input wire logic        txd,
	output logic            rxd,
	// reply byte and captured traffic
	input wire logic [7:0]  reply,
	output logic [7:0]      got,
	output int              got_cnt
);
	logic [2:0] idx;
	logic       armed;
	initial
	begin
		rxd = 1'b1;
		idx = 3'h0;
		armed = 1'b0;
		got = 8'h00;
		got_cnt = 0;
	end
	// reply msb first on the falling clock, capture on the rising one;
	// a rise counts only after a fall, so the power-up step to high is no bit
	always @(posedge sclk or negedge sclk)
	begin
		if (!sclk)
		begin
			rxd = reply[3'h7 - idx];
			armed = 1'b1;
		end
		else if (armed)
		begin
			armed = 1'b0;
			got = {got[6:0], txd};
			idx = idx + 3'h1;
			// eight bits make a byte, then invert the reply line
			if (idx == 3'h0)
			begin
				got_cnt = got_cnt + 1;
				rxd = ~rxd;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/clock_sync_serial_port_test.sv]
/* bench for the clocked serial port: register tasks and link scenarios
   assumes the link model on the serial pins */
`timescale 1ns/1ps
`default_nettype none
module clock_sync_serial_port_test;
	import serial_port_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  awaddr = 6'h00;
	logic [5:0]  araddr = 6'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, cts_n = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic [7:0]  reply = 8'h3C;
	logic [31:0] rd;
	logic [1:0]  rsp;
	wire logic   awready, wready, bvalid, arready, rvalid, sclk, sclk_oe, txd, txd_oe, rxd, rts_n;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  got;
	int          got_cnt, miscompares = 0, check_count = 0;
	time         fall_prev, fall_last;

	clock_sync_serial_port dut (.REF_CLK(ref_clk), .RST(rst), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
		.WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .SCLK_OUT(sclk), .SCLK_OE(sclk_oe), .TXD_OUT(txd), .TXD_OE(txd_oe),
		.RXD_IN(rxd), .CTS_N_IN(cts_n), .RTS_N_OUT(rts_n));
	eeprom_link_model far (.sclk(sclk), .txd(txd), .rxd(rxd), .reply(reply), .got(got),
		.got_cnt(got_cnt));

	// clock and falling-edge timestamps
	always #12.5 ref_clk = ~ref_clk;
	always @(negedge sclk)
	begin
		fall_prev = fall_last;
		fall_last = $time;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		check_count++;
		if (v !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, v, e);
		end
	endtask
	// write: address and data together, each released when taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic aw_p, w_p, b_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		b_p = 1'b1;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// local flags: the strobes themselves only change after this time step
		while (aw_p || w_p || b_p)
		begin
			@(posedge ref_clk);
			if (aw_p && awready)
			begin
				awvalid <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_p && wready)
			begin
				wvalid <= 1'b0;
				w_p = 1'b0;
			end
			if (b_p && bvalid)
			begin
				bready <= 1'b0;
				rsp = bresp;
				b_p = 1'b0;
			end
		end
	endtask
	task automatic rd_reg(input logic [5:0] a);
		logic ar_p, r_p;
		ar_p = 1'b1;
		r_p = 1'b1;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (ar_p || r_p)
		begin
			@(posedge ref_clk);
			if (ar_p && arready)
			begin
				arvalid <= 1'b0;
				ar_p = 1'b0;
			end
			if (r_p && rvalid)
			begin
				rready <= 1'b0;
				rd = rdata;
				rsp = rresp;
				r_p = 1'b0;
			end
		end
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		rd_reg(a);
		chk(rd, e);
	endtask
	task automatic poll(input logic [5:0] a, input int b);
		rd_reg(a);
		while (rd[b] !== 1'b1) rd_reg(a);
	endtask

	// main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk(OFS_MODE, 32'h0);
		rdchk(OFS_CTRL0, 32'h08);
		rdchk(OFS_CTRL1, 32'h02);
		rdchk(OFS_IRQ_CTL, 32'h0);
		for (int i = 0; i < 4; i++) rdchk(OFS_SPEC1 + 6'(4 * i), 32'h0);
		rd_reg(6'h30);
		chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
		wr(6'h30, 8'h5A);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(OFS_SPEC3, 8'hC3);
		rdchk(OFS_SPEC3, 32'hC3);
		// sync mode, msb first, handshake off, push-pull, half period 8
		wr(OFS_BAUD, 8'h07);
		wr(OFS_MODE, {5'h0, MODE_CLK_SYNC});
		wr(OFS_CTRL0, 8'h90);
		wr(OFS_TX_BUF, 8'hA5);
		rdchk(OFS_CTRL1, 32'h00);
		rdchk(OFS_TX_BUF, 32'h00);
		repeat (100) @(posedge ref_clk);
		chk({31'h0, sclk}, 32'h1);
		chk({30'h0, sclk_oe, txd_oe}, 32'h3);
		chk({31'h0, rts_n}, 32'h1);
		wr(OFS_CTRL1, 8'h01);
		wait (got_cnt == 1);
		chk({24'h0, got}, 32'hA5);
		poll(OFS_CTRL0, C0_TX_EMPTY);
		chk(32'(fall_last - fall_prev), 32'd400);
		rdchk(OFS_CTRL1, 32'h03);
		rdchk(OFS_IRQ_CTL, 32'h08);
		wr(OFS_IRQ_CTL, 8'h08);
		rdchk(OFS_IRQ_CTL, 32'h08);
		wr(OFS_IRQ_CTL, 8'h00);
		rdchk(OFS_IRQ_CTL, 32'h00);
		// reception of the reply byte
		wr(OFS_CTRL1, 8'h05);
		wr(OFS_TX_BUF, 8'h96);
		wait (got_cnt == 2);
		chk({24'h0, got}, 32'h96);
		poll(OFS_CTRL1, C1_RX_DONE);
		rdchk(OFS_RX_BUF, 32'h3C);
		rdchk(OFS_CTRL1, 32'h07);
		// prescaler by two, divider 2: half period 6, room for the pin synchroniser
		wr(OFS_CTRL0, 8'h93);
		wr(OFS_BAUD, 8'h02);
		wr(OFS_TX_BUF, 8'h11);
		wait (got_cnt == 3);
		poll(OFS_CTRL1, C1_RX_DONE);
		chk(32'(fall_last - fall_prev), 32'd300);
		reply <= 8'hE7;
		wr(OFS_TX_BUF, 8'h22);
		wait (got_cnt == 4);
		poll(OFS_CTRL0, C0_TX_EMPTY);
		rdchk(OFS_RX_BUF, 32'h10E7);
		// continuous receive: reading the buffer resends the last byte
		wr(OFS_CTRL1, 8'h25);
		rdchk(OFS_RX_BUF, 32'h10E7);
		wait (got_cnt == 5);
		chk({24'h0, got}, 32'h22);
		wr(OFS_CTRL1, 8'h00);
		rdchk(OFS_RX_BUF, 32'hE7);
		complete_run();
	end
	// hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
endmodule
bind clock_sync_serial_port serial_port_sva chk_i (.REF_CLK, .RST, .AWVALID, .AWREADY,
	.WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY,
	.RDATA, .RRESP, .SCLK_OUT, .SCLK_OE, .TXD_OUT, .TXD_OE, .RTS_N_OUT);
`default_nettype wire
